/* File: core/dsd_key_hold.sv */
// key press edge and long hold detector
module dsd_key_hold
    import dsd_pkg::*;
#(
    parameter int HOLD = dsd_pkg::HOLD_CYC
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // key level and events
    input  wire logic key,
    output logic      press_p,
    output logic      hold_p
);
    logic [CNT_W-1:0] cnt_r;
    logic             key_d_r;
    logic             done_r;
    wire              at_hold = (cnt_r == CNT_W'(HOLD - 1));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r   <= '0;
            key_d_r <= 1'b0;
            done_r  <= 1'b0;
            press_p <= 1'b0;
            hold_p  <= 1'b0;
        end else if (ce) begin
            key_d_r <= key;
            press_p <= key & ~key_d_r;
            hold_p  <= key & at_hold & ~done_r;
            // one hold event per press, however long the key stays down
            if (!key) begin
                cnt_r  <= '0;
                done_r <= 1'b0;
            end else if (at_hold) begin
                done_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule

/* File: core/dsd_pkg.sv */
// shared constants and types for the drive status display
package dsd_pkg;
    localparam int CLK_HZ    = 40_000_000;
    localparam int HOLD_MS   = 1000;
    localparam int HOLD_CYC  = CLK_HZ / 1000 * HOLD_MS;
    localparam int BLINK_MS  = 250;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int CNT_W     = 26;
    localparam int N_DIG     = 8;
    localparam int N_BITS    = 10;
    localparam int N_KEYS    = 4;
    localparam int KEY_MODE  = 0;
    localparam int KEY_UP    = 1;
    localparam int KEY_DN    = 2;
    localparam int KEY_DATA  = 3;
    // register offsets
    localparam logic [7:0] ADR_WIN   = 8'h00;
    localparam logic [7:0] ADR_ROT   = 8'h04;
    localparam logic [7:0] ADR_MATCH = 8'h08;
    localparam logic [7:0] ADR_STAT  = 8'h0C;
    localparam logic [7:0] ADR_MON   = 8'h10;
    // reset values and torque bit threshold
    localparam logic [15:0] WIN_RST   = 16'h0007;
    localparam logic [15:0] ROT_RST   = 16'h0014;
    localparam logic [15:0] MATCH_RST = 16'h000A;
    localparam logic [15:0] TRQ_MIN   = 16'h000A;
    // status register fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_KEYDIS   = 3;
    localparam int STAT_BITS_LSB = 4;
    localparam int STAT_SETERR   = 14;
    // monitor numbers
    localparam logic [3:0] MON_LAST = 4'hD;
    localparam logic [3:0] MON_IN   = 4'h5;
    localparam logic [3:0] MON_OUT  = 4'h6;
    // status bit positions
    localparam int BIT_CTRL = 0;
    localparam int BIT_MAIN = 1;
    localparam int BIT_BLK  = 2;
    localparam int BIT_POS  = 3;
    localparam int BIT_VCMP = 4;
    localparam int BIT_ROT  = 5;
    localparam int BIT_PLS  = 6;
    localparam int BIT_SCMD = 7;
    localparam int BIT_CLR  = 8;
    localparam int BIT_TRQ  = 9;
    // display characters, 0..15 are hex digits
    localparam logic [4:0] CH_BLANK = 5'h10;
    localparam logic [4:0] CH_R     = 5'h11;
    localparam logic [4:0] CH_U     = 5'h12;
    localparam logic [4:0] CH_N     = 5'h13;
    localparam logic [4:0] CH_P     = 5'h14;
    localparam logic [4:0] CH_O     = 5'h15;
    localparam logic [4:0] CH_T     = 5'h16;
    localparam logic [4:0] CH_DASH  = 5'h17;
    localparam logic [4:0] CH_CAPU  = 5'h18;
    localparam logic [4:0] CH_UPPER = 5'h19;
    localparam logic [4:0] CH_LOWER = 5'h1A;
    typedef enum logic [2:0] {
        ST_STATUS  = 3'b001,
        ST_MON_NUM = 3'b010,
        ST_MON_VAL = 3'b100
    } dsd_state_type;
    typedef enum logic [2:0] {
        SYM_BB  = 3'h0,
        SYM_RUN = 3'h1,
        SYM_POT = 3'h2,
        SYM_NOT = 3'h3,
        SYM_ALM = 3'h4,
        SYM_ERR = 3'h5,
        SYM_KEY = 3'h6
    } dsd_sym_type;
endpackage

/* File: core/dsd_seg_enc.sv */
// one digit character to seven segment pattern, segments g..a
module dsd_seg_enc
    import dsd_pkg::*;
(
    // character in, pattern out
    input  wire logic [4:0] chr,
    output logic      [6:0] seg
);
    always_comb begin
        case (chr)
            5'h00:    seg = 7'h3F;
            5'h01:    seg = 7'h06;
            5'h02:    seg = 7'h5B;
            5'h03:    seg = 7'h4F;
            5'h04:    seg = 7'h66;
            5'h05:    seg = 7'h6D;
            5'h06:    seg = 7'h7D;
            5'h07:    seg = 7'h07;
            5'h08:    seg = 7'h7F;
            5'h09:    seg = 7'h6F;
            5'h0A:    seg = 7'h77;
            5'h0B:    seg = 7'h7C;
            5'h0C:    seg = 7'h39;
            5'h0D:    seg = 7'h5E;
            5'h0E:    seg = 7'h79;
            5'h0F:    seg = 7'h71;
            CH_R:     seg = 7'h50;
            CH_U:     seg = 7'h1C;
            CH_N:     seg = 7'h54;
            CH_P:     seg = 7'h73;
            CH_O:     seg = 7'h5C;
            CH_T:     seg = 7'h78;
            CH_DASH:  seg = 7'h40;
            CH_CAPU:  seg = 7'h3E;
            CH_UPPER: seg = 7'h20;
            CH_LOWER: seg = 7'h10;
            default:  seg = 7'h00;
        endcase
    end
endmodule

/* File: core/dsd_top.sv */
// front panel status and monitor display logic
//
// Behaviour
// - power-up starts in status display mode
// - status shows bit LEDs and 3-digit symbol
// - bits for control and main supply
// - base block bit lit, dimmed when energised
// - positioning done when error below window
// - speed match within command plus/minus width
// - rotation bit when speed reaches threshold
// - pulse bit while command pulses arrive
// - speed command bit at rotation threshold
// - counter clear bit while clear input
// - torque bit at ten percent rated
// - run symbol energised, block symbol otherwise
// - inhibit symbols while travel inhibit off
// - alarm symbol shows the alarm code
// - setting error symbol on unsuitable configuration
// - reserved key operation refused except data hold, key-disabled shown in status mode
// - mode key enters monitor, shows number
// - up/down select number, editable digit flashes
// - data held one second shows value
// - next qualifying data hold returns number
// - signal monitors: off upper, on lower
// - pulse counters as eight hex digits
//
// The address map and the strobed register port were left to the implementer.
module dsd_top
    import dsd_pkg::*;
#(
    parameter int HOLD  = dsd_pkg::HOLD_CYC,
    parameter int BLINK = dsd_pkg::BLINK_CYC
) (
    // clock, reset, enable
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic                      ce,
    // register port
    input  wire logic [7:0]                addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic      [31:0]               rdata,
    // drive conditions
    input  wire logic                      ctrl_pwr_on,
    input  wire logic                      main_pwr_on,
    input  wire logic                      servo_on,
    input  wire logic [31:0]               pos_err,
    input  wire logic [15:0]               motor_speed,
    input  wire logic [15:0]               speed_cmd,
    input  wire logic [15:0]               torque_pct,
    input  wire logic                      cmd_pulse_active,
    input  wire logic                      error_counter_clear_input,
    input  wire logic                      fwd_inhibit_in,
    input  wire logic                      rev_inhibit_in,
    input  wire logic                      alarm_active,
    input  wire logic [7:0]                alarm_code,
    input  wire logic                      cfg_err_in,
    // operator keys
    input  wire logic                      key_mode,
    input  wire logic                      key_up,
    input  wire logic                      key_down,
    input  wire logic                      key_data,
    input  wire logic                      sys_check_req,
    // monitor value source
    output logic      [3:0]                mon_sel,
    input  wire logic [31:0]               mon_value,
    // display
    output logic      [dsd_pkg::N_BITS-1:0] bit_led,
    output logic      [7*dsd_pkg::N_DIG-1:0] seg
);
    import dsd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers and state
    logic [15:0]       win_r;
    logic [15:0]       rot_r;
    logic [15:0]       match_r;
    dsd_state_type     st_r;
    dsd_state_type     st_nxt;
    dsd_sym_type       sym_r;
    logic              key_dis_r;
    logic [CNT_W-1:0]  blink_cnt_r;
    logic              blink_r;
    logic [2:0]        dim_cnt_r;
    logic [N_KEYS-1:0] press_p;
    logic [N_KEYS-1:0] hold_p;

    ////////////////////////////////////////////////////////////////////
    // key event detectors
    wire [N_KEYS-1:0] keys = {key_data, key_down, key_up, key_mode};

    generate
        for (genvar k = 0; k < N_KEYS; k++) begin : g_key
            dsd_key_hold #(.HOLD(HOLD)) u_key (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .ce      (ce),
                .key     (keys[k]),
                .press_p (press_p[k]),
                .hold_p  (hold_p[k])
            );
        end
    endgenerate

    wire mode_p    = press_p[KEY_MODE];
    wire up_p      = press_p[KEY_UP];
    wire dn_p      = press_p[KEY_DN];
    wire data_hold = hold_p[KEY_DATA];

    ////////////////////////////////////////////////////////////////////
    // status bit conditions
    wire [31:0] pos_mag  = pos_err[31] ? 32'(-pos_err) : pos_err;
    wire [15:0] spd_mag  = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
    wire [15:0] cmd_mag  = speed_cmd[15] ? 16'(-speed_cmd) : speed_cmd;
    wire [15:0] trq_mag  = torque_pct[15] ? 16'(-torque_pct) : torque_pct;
    wire [16:0] spd_diff = {motor_speed[15], motor_speed} - {speed_cmd[15], speed_cmd};
    wire [16:0] diff_mag = spd_diff[16] ? 17'(-spd_diff) : spd_diff;
    // dimming by a 1-in-8 duty keeps the flop-only output path
    wire        dim_on   = (dim_cnt_r == 3'h0);

    wire [N_BITS-1:0] bits_nxt;
    assign bits_nxt[BIT_CTRL] = ctrl_pwr_on;
    assign bits_nxt[BIT_MAIN] = main_pwr_on;
    assign bits_nxt[BIT_BLK]  = ~servo_on | dim_on;
    assign bits_nxt[BIT_POS]  = pos_mag < {16'h0000, win_r};
    assign bits_nxt[BIT_VCMP] = diff_mag <= {1'b0, match_r};
    assign bits_nxt[BIT_ROT]  = spd_mag >= rot_r;
    assign bits_nxt[BIT_PLS]  = cmd_pulse_active;
    assign bits_nxt[BIT_SCMD] = cmd_mag >= rot_r;
    assign bits_nxt[BIT_CLR]  = error_counter_clear_input;
    assign bits_nxt[BIT_TRQ]  = trq_mag >= TRQ_MIN;

    ////////////////////////////////////////////////////////////////////
    // symbol selection
    // zero windows make the completion and match bits meaningless
    wire set_err = cfg_err_in | (win_r == 16'h0000) | (match_r == 16'h0000);
    wire dsd_sym_type sym_nxt =
        key_dis_r      ? SYM_KEY :
        alarm_active   ? SYM_ALM :
        set_err        ? SYM_ERR :
        !fwd_inhibit_in ? SYM_POT :
        !rev_inhibit_in ? SYM_NOT :
        servo_on       ? SYM_RUN : SYM_BB;

    wire [14:0] sym_chr =
        (sym_r == SYM_RUN) ? {CH_R, CH_U, CH_N} :
        (sym_r == SYM_POT) ? {CH_P, CH_O, CH_T} :
        (sym_r == SYM_NOT) ? {CH_N, CH_O, CH_T} :
        (sym_r == SYM_ALM) ? {5'h0A, 1'b0, alarm_code[7:4], 1'b0, alarm_code[3:0]} :
        (sym_r == SYM_ERR) ? {5'h0E, CH_R, CH_R} :
        (sym_r == SYM_KEY) ? {CH_DASH, CH_DASH, CH_DASH} :
                             {CH_BLANK, 5'h0B, 5'h0B};

    ////////////////////////////////////////////////////////////////////
    // mode state machine
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_STATUS: begin
                if (mode_p && !sys_check_req) begin
                    st_nxt = ST_MON_NUM;
                end
            end
            ST_MON_NUM: begin
                if (data_hold) begin
                    st_nxt = ST_MON_VAL;
                end else if (mode_p && !sys_check_req) begin
                    st_nxt = ST_STATUS;
                end
            end
            ST_MON_VAL: begin
                if (data_hold) begin
                    st_nxt = ST_MON_NUM;
                end
            end
            default: st_nxt = ST_STATUS;
        endcase
    end

    // monitor number steps with wrap over the fourteen entries
    wire [3:0] sel_up  = (mon_sel == MON_LAST) ? 4'h0 : mon_sel + 4'h1;
    wire [3:0] sel_dn  = (mon_sel == 4'h0) ? MON_LAST : mon_sel - 4'h1;
    wire       sel_act = (st_r == ST_MON_NUM) && !sys_check_req;
    wire [3:0] sel_nxt = (sel_act && up_p) ? sel_up :
                         (sel_act && dn_p) ? sel_dn : mon_sel;

    // key-disabled stays until the next accepted key press
    wire any_p       = |press_p;
    wire key_dis_nxt = sys_check_req | (key_dis_r & ~any_p);

    ////////////////////////////////////////////////////////////////////
    // digit characters
    wire         bit_mode = (mon_sel == MON_IN) || (mon_sel == MON_OUT);
    wire [4:0]   flash_lo = blink_r ? {1'b0, mon_sel} : CH_BLANK;
    wire [39:0]  num_chr  = {CH_BLANK, CH_BLANK, CH_BLANK, CH_CAPU, CH_N,
                             5'h00, 5'h00, flash_lo};
    wire [39:0]  stat_chr = {25'h0_0000 | {5{CH_BLANK}}, sym_chr};
    wire [39:0]  cur_chr;
    wire [6:0]   seg_dig [N_DIG];

    generate
        for (genvar d = 0; d < N_DIG; d++) begin : g_dig
            // high level (off) lights the upper half, low level the lower
            wire [4:0] bit_chr = mon_value[d] ? CH_UPPER : CH_LOWER;
            wire [4:0] hex_chr = {1'b0, mon_value[4*d +: 4]};
            wire [4:0] val_chr = bit_mode ? bit_chr : hex_chr;
            assign cur_chr[5*d +: 5] =
                (st_r == ST_MON_VAL) ? val_chr :
                (st_r == ST_MON_NUM) ? num_chr[5*d +: 5] : stat_chr[5*d +: 5];
            dsd_seg_enc u_enc (
                .chr (cur_chr[5*d +: 5]),
                .seg (seg_dig[d])
            );
        end
    endgenerate

    wire [7*N_DIG-1:0] seg_nxt = {seg_dig[7], seg_dig[6], seg_dig[5], seg_dig[4],
                                  seg_dig[3], seg_dig[2], seg_dig[1], seg_dig[0]};

    ////////////////////////////////////////////////////////////////////
    // register port decode
    wire wr_win   = wr_stb && (addr == ADR_WIN);
    wire wr_rot   = wr_stb && (addr == ADR_ROT);
    wire wr_match = wr_stb && (addr == ADR_MATCH);
    wire [31:0] stat_word;
    assign stat_word[STAT_MODE_LSB +: 3]      = st_r;
    assign stat_word[STAT_KEYDIS]             = key_dis_r;
    assign stat_word[STAT_BITS_LSB +: N_BITS] = bit_led;
    assign stat_word[STAT_SETERR]             = set_err;
    assign stat_word[31:STAT_SETERR+1]        = '0;
    wire [31:0] rd_mux;
    assign rd_mux = (addr == ADR_WIN)   ? {16'h0000, win_r} :
                    (addr == ADR_ROT)   ? {16'h0000, rot_r} :
                    (addr == ADR_MATCH) ? {16'h0000, match_r} :
                    (addr == ADR_STAT)  ? stat_word :
                    (addr == ADR_MON)   ? {28'h000_0000, mon_sel} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            win_r   <= WIN_RST;
            rot_r   <= ROT_RST;
            match_r <= MATCH_RST;
            rdata   <= '0;
        end else if (ce) begin
            if (wr_win) win_r <= wdata[15:0];
            if (wr_rot) rot_r <= wdata[15:0];
            if (wr_match) match_r <= wdata[15:0];
            rdata <= rd_stb ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r      <= ST_STATUS;
            sym_r     <= SYM_BB;
            key_dis_r <= 1'b0;
            mon_sel   <= 4'h0;
            bit_led   <= '0;
            seg       <= '0;
        end else if (ce) begin
            st_r      <= st_nxt;
            sym_r     <= sym_nxt;
            key_dis_r <= key_dis_nxt;
            mon_sel   <= sel_nxt;
            bit_led   <= bits_nxt;
            seg       <= seg_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b1;
            dim_cnt_r   <= 3'h0;
        end else if (ce) begin
            dim_cnt_r <= dim_cnt_r + 3'h1;
            if (blink_cnt_r == CNT_W'(BLINK - 1)) begin
                blink_cnt_r <= '0;
                blink_r     <= ~blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_num_shown;
        st_r == ST_MON_NUM;
    endsequence

    sequence s_val_shown;
        st_r == ST_MON_VAL;
    endsequence

    a_status_stays: assert property (
        (ce && st_r == ST_STATUS && !mode_p) |=> st_r == ST_STATUS)
        else $error("status mode left without mode key");

    a_supply_bits: assert property (
        ce |=> bit_led[BIT_CTRL] == $past(ctrl_pwr_on)
            && bit_led[BIT_MAIN] == $past(main_pwr_on))
        else $error("supply bits wrong");

    a_block_lit: assert property (
        (ce && !servo_on) |=> bit_led[BIT_BLK])
        else $error("base block bit dark while disabled");

    a_pos_window: assert property (
        ce |=> bit_led[BIT_POS] == ($past(pos_mag) < {16'h0000, $past(win_r)}))
        else $error("positioning done bit wrong");

    a_rotation_bits: assert property (
        ce |=> bit_led[BIT_ROT] == ($past(spd_mag) >= $past(rot_r))
            && bit_led[BIT_SCMD] == ($past(cmd_mag) >= $past(rot_r)))
        else $error("rotation or speed command bit wrong");

    a_torque_bit: assert property (
        (ce && trq_mag == 16'h0009) |=> !bit_led[BIT_TRQ])
        else $error("torque bit lit below ten percent");

    a_alarm_first: assert property (
        (ce && alarm_active && !key_dis_r) |=> sym_r == SYM_ALM)
        else $error("alarm symbol not chosen");

    a_key_refused: assert property (
        (ce && sys_check_req && !data_hold) |=> key_dis_r && $stable(st_r) && $stable(mon_sel))
        else $error("reserved key operation not refused");

    a_enter_monitor: assert property (
        (ce && st_r == ST_STATUS && mode_p && !sys_check_req) |=> s_num_shown)
        else $error("mode key did not enter monitor mode");

    a_hold_value: assert property (
        (ce && data_hold) ##0 s_num_shown |=> s_val_shown ##1 (!ce || st_r != ST_STATUS))
        else $error("data hold did not show value");

    a_value_back: assert property (
        (ce && data_hold) ##0 s_val_shown |=> s_num_shown)
        else $error("data hold did not return to number");
endmodule

/* File: testbench/dsd_panel_model.sv */
// operator keypad and monitor value source beside the display block
module dsd_panel_model
    import dsd_pkg::*;
#(
    parameter int HOLD = 20
) (
    // clock and monitor select
    input  wire logic        sys_clk,
    input  wire logic [3:0]  mon_sel,
    // monitor value and keys, held = high
    output logic      [31:0] mon_value,
    output logic             key_mode,
    output logic             key_up,
    output logic             key_down,
    output logic             key_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N_KEYS-1:0] keys = '0;
    assign {key_data, key_down, key_up, key_mode} = keys;
    // the input bit monitor and the counter get distinct patterns
    assign mon_value = (mon_sel == MON_IN) ? 32'h0000_00A5 :
                       (mon_sel == 4'hC)   ? 32'h8543_2A10 : {28'h000_0000, mon_sel};
    // short tap, released long before a hold can mature
    task automatic tap(input int k);
        @(posedge sys_clk);
        keys[k] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        keys[k] <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    // data key held past the hold time
    task automatic hold_data;
        @(posedge sys_clk);
        keys[KEY_DATA] <= 1'b1;
        repeat (HOLD + 3) @(posedge sys_clk);
        keys[KEY_DATA] <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

/* File: testbench/test_dsd_top.sv */
// self-checking bench for the drive status display
module test_dsd_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dsd_pkg::*;
    logic        sys_clk, rst_b, ce, wr_stb, rd_stb, servo_on, sys_check_req;
    logic [7:0]  addr, alarm_code;
    logic [31:0] wdata, rdata, pos_err, mon_value, d;
    logic [15:0] motor_speed, speed_cmd, torque_pct;
    logic        ctrl_pwr_on, main_pwr_on, cmd_pulse_active, error_counter_clear_input;
    logic        fwd_inhibit_in, rev_inhibit_in, alarm_active, cfg_err_in;
    logic        key_mode, key_up, key_down, key_data;
    logic [3:0]  mon_sel;
    logic [9:0]  bit_led;
    logic [55:0] seg;
    int          num_errors = 0;
    int          n_tests = 0;
    localparam logic [6:0] HX [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
        7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    dsd_top #(.HOLD(20), .BLINK(8)) u_dsd_top (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .ctrl_pwr_on(ctrl_pwr_on), .main_pwr_on(main_pwr_on), .servo_on(servo_on),
        .pos_err(pos_err), .motor_speed(motor_speed), .speed_cmd(speed_cmd),
        .torque_pct(torque_pct), .cmd_pulse_active(cmd_pulse_active),
        .error_counter_clear_input(error_counter_clear_input),
        .fwd_inhibit_in(fwd_inhibit_in), .rev_inhibit_in(rev_inhibit_in),
        .alarm_active(alarm_active), .alarm_code(alarm_code), .cfg_err_in(cfg_err_in),
        .key_mode(key_mode), .key_up(key_up), .key_down(key_down), .key_data(key_data),
        .sys_check_req(sys_check_req), .mon_sel(mon_sel), .mon_value(mon_value),
        .bit_led(bit_led), .seg(seg));
    dsd_panel_model #(.HOLD(20)) u_dsd_panel_model (.sys_clk(sys_clk), .mon_sel(mon_sel),
        .mon_value(mon_value), .key_mode(key_mode), .key_up(key_up),
        .key_down(key_down), .key_data(key_data));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_out(input logic [55:0] got, input logic [55:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: register %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask
    // three edges covers output register plus symbol stage
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic apply(input logic c, m, input logic [31:0] pe,
                         input logic [15:0] sp, sc, tq, input logic [9:0] exp);
        @(posedge sys_clk);
        {ctrl_pwr_on, main_pwr_on, pos_err, motor_speed, speed_cmd} <= {c, m, pe, sp, sc};
        torque_pct <= tq;
        {cmd_pulse_active, error_counter_clear_input} <= {2{exp[6]}};
        settle;
        chk_out(bit_led, exp);
    endtask
    task automatic sym(input logic s, f, r, c, a);
        @(posedge sys_clk);
        {servo_on, fwd_inhibit_in, rev_inhibit_in, cfg_err_in, alarm_active} <= {s, f, r, c, a};
        settle;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_bits;
        int cnt;
        cnt = 0;
        apply(1, 0, 32'h0000_0006, 16'h0000, 16'h0000, 16'h0009, 10'h01D);
        apply(0, 1, 32'hFFFF_FFF9, 16'h0014, 16'h001F, 16'hFFF6, 10'h3E6);
        apply(1, 1, 32'h0000_0000, 16'hFFED, 16'hFFE3, 16'h000A, 10'h29F);
        wr(ADR_WIN, 32'h0000_0005);
        apply(1, 1, 32'h0000_0005, 16'hFFED, 16'hFFE3, 16'h000A, 10'h297);
        @(posedge sys_clk);
        {ce, ctrl_pwr_on} <= 2'b00;
        settle;
        chk_out(bit_led[BIT_CTRL], 1);
        @(posedge sys_clk);
        {ce, ctrl_pwr_on, servo_on} <= 3'b111;
        settle;
        repeat (16) begin
            @(negedge sys_clk);
            cnt += bit_led[BIT_BLK];
        end
        chk_out(cnt, 2);
    endtask
    task automatic t_symbols;
        logic [20:0] s_bb, s_run, s_pot, s_not;
        sym(0, 1, 1, 0, 0);
        s_bb = seg[20:0];
        chk_out(seg[55:21], 0);
        sym(1, 1, 1, 0, 0);
        s_run = seg[20:0];
        chk_out(s_run != s_bb, 1);
        sym(1, 0, 1, 0, 0);
        s_pot = seg[20:0];
        chk_out(s_pot != s_run, 1);
        sym(1, 1, 0, 0, 0);
        s_not = seg[20:0];
        chk_out(s_not != s_run && s_not != s_pot, 1);
        sym(1, 0, 0, 1, 0);
        chk_out(seg[20:0] != s_pot, 1);
        rd(ADR_STAT);
        chk_reg(d[STAT_SETERR], 1);
        sym(1, 0, 0, 1, 1);
        chk_out(seg[13:0], {HX[3], HX[10]});
        sym(0, 1, 1, 0, 0);
        chk_out(seg[20:0], s_bb);
        wr(ADR_WIN, 32'h0000_0000);
        rd(ADR_STAT);
        chk_reg(d[STAT_SETERR], 1);
        wr(ADR_WIN, 32'h0000_0007);
    endtask
    task automatic t_keys;
        logic [1:0] saw;
        saw = 2'b00;
        sys_check_req <= 1'b1;
        u_dsd_panel_model.tap(KEY_MODE);
        rd(ADR_STAT);
        chk_reg(d[3:0], 4'h9);
        chk_out(seg[20:14] == seg[6:0] && seg[6:0] != 0, 1);
        @(posedge sys_clk);
        sys_check_req <= 1'b0;
        u_dsd_panel_model.tap(KEY_UP);
        u_dsd_panel_model.tap(KEY_MODE);
        rd(ADR_STAT);
        chk_reg(d[3:0], 4'h2);
        chk_out(seg[20:14], HX[0]);
        repeat (20) begin
            @(negedge sys_clk);
            saw |= {seg[6:0] == 0, seg[6:0] == HX[0]};
        end
        chk_out(saw, 2'b11);
        u_dsd_panel_model.tap(KEY_DN);
        chk_out(mon_sel, 4'hD);
        u_dsd_panel_model.tap(KEY_DN);
        u_dsd_panel_model.hold_data;
        rd(ADR_STAT);
        chk_reg(d[2:0], 3'b100);
        for (int i = 0; i < 8; i++) chk_out(seg[7*i+:7], HX[4'(32'h8543_2A10 >> 4*i)]);
        u_dsd_panel_model.tap(KEY_DATA);
        rd(ADR_STAT);
        chk_reg(d[2:0], 3'b100);
        u_dsd_panel_model.hold_data;
        rd(ADR_STAT);
        chk_reg(d[2:0], 3'b010);
        repeat (7) u_dsd_panel_model.tap(KEY_UP);
        chk_out(mon_sel, MON_IN);
        u_dsd_panel_model.hold_data;
        settle;
        for (int i = 0; i < 8; i++) chk_out(seg[7*i+:7], (8'hA5 >> i) & 1 ? 7'h20 : 7'h10);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        num_errors++;
        results;
    end
    initial begin
        {rst_b, wr_stb, rd_stb, servo_on, sys_check_req, alarm_active, cfg_err_in} = '0;
        {ce, fwd_inhibit_in, rev_inhibit_in} = 3'b111;
        {addr, wdata, pos_err, motor_speed, speed_cmd, torque_pct} = '0;
        {ctrl_pwr_on, main_pwr_on, cmd_pulse_active, error_counter_clear_input} = '0;
        alarm_code = 8'h3A;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_out(seg, 0);
        chk_out(bit_led, 0);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(ADR_STAT);
        chk_reg(d[2:0], 3'b001);
        rd(ADR_ROT);
        chk_reg(d, 32'h0000_0014);
        rd(8'h20);
        chk_reg(d, 32'h0000_0000);
        t_bits;
        t_symbols;
        t_keys;
        results;
    end
endmodule
